// >>> src/sbf_node.sv
// device end: selection matcher, byte source, byte sink and frame observer
// assumes the shared line through sbf_link_if and static group codes
//
// Contract
// - good data frame: header, type, data, 011, 0
// - initiator selects sender group and receiver group
// - selected source drives size code after header
// - source reading 111 stops, sends no data
// - uncancelled source sends 1..32 byte data
// - cancelled frame: header, 111, jam bit
// - full sink or empty source cancels
// - already-set semaphore cancels its set frame
// - cancel by driving all type bits one
// - on 111 expect no data nor status
// - observer signals line free after cancel
// - own initiator's observer reports the cancellation
// - noise sync loss jams with long ones
// - jam bit one marks frame jammed
// - jammed frame changes no state anywhere; sink bytes already written to snk_mem during data stay
// - initiator resends jammed frame after resync
// - size code three bits, gives byte count
// - set while set, reset while clear cancel
`timescale 1ns/1ps
`default_nettype none

module sbf_node
   import sbf_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   sbf_link_if.dev link,
   input wire logic [CODE_W-1:0] src_code_cfg,
   input wire logic [CODE_W-1:0] snk_code_cfg,
   input wire logic [CODE_W-1:0] ff_code_cfg,
   input wire logic ld_we,
   input wire logic [4:0] ld_idx,
   input wire logic [7:0] ld_data,
   input wire logic ld_commit,
   input wire logic [2:0] ld_len,
   input wire logic [4:0] rd_idx,
   input wire logic dispose,
   output logic src_loaded,
   output logic src_sent,
   output logic snk_full,
   output logic [2:0] snk_len,
   output logic [7:0] rd_data,
   output logic sem_flag,
   output logic jam_seen,
   output logic cancel_report
);

   typedef struct packed {
      dev_st_t st;
      logic s1;
      logic s2;
      logic [3:0] ph;
      logic [8:0] cnt;
      logic smp;
      logic drv;
      logic [19:0] sh;
      logic [2:0] txp;
      logic [2:0] ft;
      logic [8:0] dlast;
      logic src_hit;
      logic snk_hit;
      logic set_req;
      logic rst_req;
      logic cxl;
      logic [7:0] rxb;
      logic [31:0][7:0] src_mem;
      logic [31:0][7:0] snk_mem;
      logic [2:0] src_len;
      logic [2:0] snk_len;
      logic src_loaded;
      logic snk_full;
      logic sem;
      logic sent;
      logic jam;
      logic free;
      logic crep;
      logic busy;
      logic [7:0] rd_data;
   } dev_state_t;

   dev_state_t q;
   dev_state_t r;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic lv;
      logic bv;
      logic [19:0] shn;
      logic [2:0] ftn;
      logic [8:0] nb;
      lv = 1'b0;
      bv = 1'b0;
      shn = '0;
      ftn = '0;
      nb = '0;
      r = q;
      r.sent = 1'b0;
      r.jam = 1'b0;
      r.free = 1'b0;
      r.crep = 1'b0;
      // line sync; the first stage feeds only the second
      r.s1 = link.sd_i;
      r.s2 = q.s1;
      lv = ~q.s2;
      bv = q.smp;
      // user side: dispose first so a same-cycle commit wins
      if (dispose)
         r.snk_full = 1'b0;
      if (ld_we)
         r.src_mem[ld_idx] = ld_data;
      r.rd_data = q.snk_mem[rd_idx];
      if (q.st == D_IDLE)
      begin
         r.ph = 4'h0;
         if (lv)
         begin
            r.st = D_HDR;
            r.cnt = 9'h000;
            r.cxl = 1'b0;
         end
      end
      else
      begin
         r.ph = next_ph(q.ph);
         if (q.ph == SMP_PH)
            r.smp = lv;
         // an unstable bit means we lost the bit grid
         if (q.ph == CHK_PH && lv != q.smp && q.st != D_JAM && q.st != D_WAITI)
         begin
            r.st = D_JAM;
            r.cnt = 9'h000;
            r.drv = 1'b1;
            r.jam = 1'b1;
         end
         else if (q.ph == LAST_PH)
         begin
            r.cnt = 9'(q.cnt + 9'h001);
            nb = r.cnt;
            unique case (q.st)
               D_HDR:
               begin
                  shn = {q.sh[18:0], bv};
                  r.sh = shn;
                  if (q.cnt == HDR_LAST)
                  begin
                     r.src_hit = shn[19:10] == src_code_cfg;
                     r.snk_hit = shn[9:0] == snk_code_cfg;
                     r.set_req = shn[19:10] == ff_code_cfg;
                     r.rst_req = shn[9:0] == ff_code_cfg;
                     // not ready or flip-flop already in target state
                     if ((r.src_hit && !q.src_loaded) || (r.snk_hit && q.snk_full) ||
                         (r.set_req && q.sem) || (r.rst_req && !q.sem))
                        r.txp = FT_CANCEL;
                     else if (r.src_hit)
                        r.txp = q.src_len;
                     else
                        r.txp = FT_FLAG;
                     r.drv = r.txp[2];
                     r.st = D_TYPE;
                     r.cnt = 9'h000;
                  end
               end
               D_TYPE:
               begin
                  ftn = {q.ft[1:0], bv};
                  r.ft = ftn;
                  r.txp = {q.txp[1:0], 1'b0};
                  r.drv = r.txp[2];
                  if (q.cnt == TYPE_LAST)
                  begin
                     r.cnt = 9'h000;
                     if (ftn == FT_CANCEL)
                     begin
                        // cancelled: no data, no status, straight to jam bit
                        r.cxl = 1'b1;
                        r.drv = 1'b0;
                        r.st = D_JAMB;
                     end
                     else if (ftn == FT_FLAG)
                     begin
                        // flip-flop frames answer set 010, reset 001
                        r.txp = {1'b0, q.set_req, q.rst_req};
                        r.drv = 1'b0;
                        r.st = D_STAT;
                     end
                     else
                     begin
                        r.dlast = data_last_bit(ftn);
                        r.drv = q.src_hit && q.src_mem[0][7];
                        r.st = D_DATA;
                     end
                  end
               end
               D_DATA:
               begin
                  r.rxb = {q.rxb[6:0], bv};
                  if (q.cnt[2:0] == 3'h7 && q.snk_hit)
                     r.snk_mem[q.cnt[7:3]] = r.rxb;
                  if (q.cnt == q.dlast)
                  begin
                     r.txp = (q.src_hit || q.snk_hit) ? ST_DATA_OK : ST_NONE;
                     r.drv = r.txp[2];
                     r.st = D_STAT;
                     r.cnt = 9'h000;
                  end
                  else
                     r.drv = q.src_hit && q.src_mem[nb[7:3]][3'h7 - nb[2:0]];
               end
               D_STAT:
               begin
                  r.txp = {q.txp[1:0], 1'b0};
                  r.drv = r.txp[2];
                  if (q.cnt == STAT_LAST)
                  begin
                     r.drv = 1'b0;
                     r.st = D_JAMB;
                     r.cnt = 9'h000;
                  end
               end
               D_JAMB:
               begin
                  r.cnt = 9'h000;
                  if (bv)
                  begin
                     // jammed: drop every flag update of the frame; sink bytes already written to snk_mem stay
                     r.jam = 1'b1;
                     r.st = D_WAITI;
                  end
                  else
                  begin
                     r.st = D_IDLE;
                     r.free = 1'b1;
                     if (q.cxl)
                        r.crep = link.ini_active;
                     else
                     begin
                        if (q.snk_hit)
                        begin
                           r.snk_full = 1'b1;
                           r.snk_len = q.ft;
                        end
                        if (q.src_hit)
                        begin
                           r.src_loaded = 1'b0;
                           r.sent = 1'b1;
                        end
                        if (q.set_req)
                           r.sem = 1'b1;
                        if (q.rst_req)
                           r.sem = 1'b0;
                     end
                  end
               end
               D_JAM:
               begin
                  // long run of ones so every module sees a one jam bit
                  if (q.cnt == JAM_LAST)
                  begin
                     r.drv = 1'b0;
                     r.st = D_WAITI;
                     r.cnt = 9'h000;
                  end
               end
               D_WAITI:
               begin
                  // resync: the line must stay idle for a full run of bits
                  if (bv)
                     r.cnt = 9'h000;
                  else if (q.cnt == IDLE_LAST)
                  begin
                     r.st = D_IDLE;
                     r.free = 1'b1;
                  end
               end
               default:
               begin
                  r.st = D_IDLE;
               end
            endcase
         end
      end
      // a load after this frame's commit must survive it
      if (ld_commit)
      begin
         r.src_loaded = 1'b1;
         r.src_len = ld_len;
      end
      r.busy = r.st != D_IDLE;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         q <= '0;
         q.s1 <= 1'b1;
         q.s2 <= 1'b1;
      end
      else
         q <= r;
   end

   // ---------------------------------------------------------------
   // outputs, all straight from state
   // ---------------------------------------------------------------
   assign link.dev_sd_o = 1'b0;
   assign link.dev_sd_oe = q.drv;
   assign link.obs_busy = q.busy;
   assign link.obs_free = q.free;
   assign link.obs_cancel = q.crep;
   assign link.obs_jam = q.jam;
   assign src_loaded = q.src_loaded;
   assign src_sent = q.sent;
   assign snk_full = q.snk_full;
   assign snk_len = q.snk_len;
   assign rd_data = q.rd_data;
   assign sem_flag = q.sem;
   assign jam_seen = q.jam;
   assign cancel_report = q.crep;

endmodule

`default_nettype wire

// >>> include/sbf_pkg.sv
// shared constants, types and helpers for the wired-or serial frame logic
// assumes one 20 mhz clock for both ends and an active-low shared line
package sbf_pkg;

   // ---------------------------------------------------------------
   // bit timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int BIT_NS = 800;
   localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] LAST_PH = 4'(BIT_CYC - 1);
   localparam logic [3:0] SMP_PH = 4'(BIT_CYC / 2);
   localparam logic [3:0] CHK_PH = 4'((BIT_CYC * 3) / 4);

   // ---------------------------------------------------------------
   // subframe lengths, as index of the last bit
   // ---------------------------------------------------------------
   localparam int CODE_W = 10;
   localparam logic [8:0] HDR_LAST = 9'h014;
   localparam logic [8:0] TYPE_LAST = 9'h002;
   localparam logic [8:0] STAT_LAST = 9'h002;
   localparam logic [8:0] JAM_LAST = 9'h02f;
   localparam logic [8:0] IDLE_LAST = 9'h00f;

   // ---------------------------------------------------------------
   // frame type and status codes
   // ---------------------------------------------------------------
   localparam logic [2:0] FT_CANCEL = 3'h7;
   localparam logic [2:0] FT_FLAG = 3'h0;
   localparam logic [2:0] ST_DATA_OK = 3'h3;
   localparam logic [2:0] ST_NONE = 3'h0;

   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_HDR = 3'b001,
      D_TYPE = 3'b010,
      D_DATA = 3'b011,
      D_STAT = 3'b100,
      D_JAMB = 3'b101,
      D_JAM = 3'b110,
      D_WAITI = 3'b111
   } dev_st_t;

   typedef enum logic [1:0] {
      I_IDLE = 2'b00,
      I_SEND = 2'b01,
      I_WAIT = 2'b10,
      I_RETRY = 2'b11
   } ini_st_t;

   // last data bit index for a size code: 001 -> 1 byte ... 110 -> 32 bytes
   function automatic logic [8:0] data_last_bit(input logic [2:0] code);
      data_last_bit = 9'((9'h008 << (code - 3'h1)) - 9'h001);
   endfunction

   // next bit-phase value, wrapping at the end of a bit
   function automatic logic [3:0] next_ph(input logic [3:0] ph);
      next_ph = (ph == LAST_PH) ? 4'h0 : 4'(ph + 4'h1);
   endfunction

endpackage

// >>> include/sbf_link_if.sv
// shared serial line plus the local observer-to-initiator signals
// assumes the testbench instantiates it once and joins both ends
`timescale 1ns/1ps
`default_nettype none

interface sbf_link_if;
   // open-drain line, low = logical one
   logic dev_sd_o;
   logic dev_sd_oe;
   logic ini_sd_o;
   logic ini_sd_oe;
   logic sd_i;
   // stray pull-down for noise tests only; held low otherwise
   logic noise;
   // observer status towards the local initiator
   logic obs_busy;
   logic obs_free;
   logic obs_cancel;
   logic obs_jam;
   logic ini_active;

   // wired-or resolution: any enabled low output pulls the line low
   assign sd_i = ~((dev_sd_oe & ~dev_sd_o) | (ini_sd_oe & ~ini_sd_o) | noise);

   modport dev (
      output dev_sd_o,
      output dev_sd_oe,
      input sd_i,
      output obs_busy,
      output obs_free,
      output obs_cancel,
      output obs_jam,
      input ini_active
   );

   modport ini (
      output ini_sd_o,
      output ini_sd_oe,
      input sd_i,
      input obs_busy,
      input obs_free,
      input obs_cancel,
      input obs_jam,
      output ini_active
   );
endinterface

`default_nettype wire

// >>> src/sbf_initiator.sv
// frame initiator end: sends the header and resends jammed frames
// assumes the local observer in the device end reports bus state
`timescale 1ns/1ps
`default_nettype none

module sbf_initiator
   import sbf_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   sbf_link_if.ini link,
   input wire logic req_valid,
   input wire logic [CODE_W-1:0] req_s,
   input wire logic [CODE_W-1:0] req_r,
   output logic req_ready,
   output logic done,
   output logic cancelled,
   output logic retry
);

   typedef struct packed {
      ini_st_t st;
      logic [3:0] ph;
      logic [8:0] cnt;
      logic [20:0] sh;
      logic [19:0] hdr;
      logic drv;
      logic active;
      logic ready;
      logic done;
      logic cancelled;
      logic retry;
   } ini_state_t;

   ini_state_t q;
   ini_state_t r;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      r = q;
      r.done = 1'b0;
      r.cancelled = 1'b0;
      r.retry = 1'b0;
      unique case (q.st)
         I_IDLE:
         begin
            if (req_valid && q.ready && !link.obs_busy)
            begin
               // s field names a sender group, r field a receiver group
               r.hdr = {req_s, req_r};
               r.sh = {1'b1, req_s, req_r};
               r.drv = 1'b1;
               r.st = I_SEND;
               r.ph = 4'h0;
               r.cnt = 9'h000;
               r.active = 1'b1;
            end
         end
         I_SEND:
         begin
            r.ph = next_ph(q.ph);
            if (link.obs_jam)
            begin
               r.drv = 1'b0;
               r.st = I_RETRY;
               r.retry = 1'b1;
            end
            else if (q.ph == LAST_PH)
            begin
               if (q.cnt == HDR_LAST)
               begin
                  // header done, the rest of the frame belongs to others
                  r.drv = 1'b0;
                  r.st = I_WAIT;
               end
               else
               begin
                  r.sh = {q.sh[19:0], 1'b0};
                  r.drv = r.sh[20];
                  r.cnt = 9'(q.cnt + 9'h001);
               end
            end
         end
         I_WAIT:
         begin
            if (link.obs_jam)
            begin
               r.st = I_RETRY;
               r.retry = 1'b1;
            end
            else if (link.obs_free)
            begin
               r.done = 1'b1;
               r.cancelled = link.obs_cancel;
               r.active = 1'b0;
               r.st = I_IDLE;
            end
         end
         I_RETRY:
         begin
            // resend the same header once the line is back in sync
            if (!link.obs_busy)
            begin
               r.sh = {1'b1, q.hdr};
               r.drv = 1'b1;
               r.st = I_SEND;
               r.ph = 4'h0;
               r.cnt = 9'h000;
            end
         end
      endcase
      r.ready = (r.st == I_IDLE) && !link.obs_busy;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         q <= '0;
      else
         q <= r;
   end

   assign link.ini_sd_o = 1'b0;
   assign link.ini_sd_oe = q.drv;
   assign link.ini_active = q.active;
   assign req_ready = q.ready;
   assign done = q.done;
   assign cancelled = q.cancelled;
   assign retry = q.retry;

endmodule

`default_nettype wire

// >>> dv/sbf_link_asserts.sv
// checker for the shared serial line and the observer-to-initiator signals
// assumes one mclk domain; the bench instantiates it beside sbf_link_if
`timescale 1ns/1ps
`default_nettype none

module sbf_link_asserts (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic dev_sd_oe,
   input wire logic ini_sd_oe,
   input wire logic obs_busy,
   input wire logic obs_free,
   input wire logic obs_cancel,
   input wire logic obs_jam,
   input wire logic ini_active
);
   // ---------------------------------------------------------------
   // helper: cycles since the local frame began
   // ---------------------------------------------------------------
   logic [12:0] frame_cnt_reg;
   logic [12:0] frame_cnt_next;

   // saturates so a hung frame never wraps back into range
   always_comb
   begin
      frame_cnt_next = frame_cnt_reg;
      if (!ini_active)
         frame_cnt_next = 13'h0000;
      else if (frame_cnt_reg != 13'h1fff)
         frame_cnt_next = 13'(frame_cnt_reg + 13'h0001);
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         frame_cnt_reg <= 13'h0000;
      else
         frame_cnt_reg <= frame_cnt_next;
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_hdr_start;
      $rose(ini_sd_oe);
   endsequence

   sequence s_cancel_end;
      obs_free && ini_active;
   endsequence

   // a bit on the line lasts 16 cycles, so half of it must hold
   a_start_bit_hold: assert property (s_hdr_start |-> ini_sd_oe [*8]) else $error("header bit too short");
   a_dev_bit_hold: assert property ($rose(dev_sd_oe) |-> dev_sd_oe [*8]) else $error("device bit too short");
   // a noise jam may start under the header; the initiator lets go one cycle later
   a_dev_quiet_hdr: assert property (ini_sd_oe && !obs_jam |-> !dev_sd_oe) else $error("device drives in header");
   a_busy_follows: assert property ($rose(ini_active) |-> ##[1:40] obs_busy) else $error("observer missed frame");
   a_free_pulse: assert property (obs_free |=> !obs_free) else $error("free not a pulse");
   a_free_ends_busy: assert property (obs_free |=> !obs_busy) else $error("busy after free");
   a_cancel_with_free: assert property (obs_cancel |-> s_cancel_end) else $error("cancel without free");
   a_jam_pulse: assert property (obs_jam |=> !obs_jam) else $error("jam not a pulse");
   // header 21 bits, type 3, jam 1: about 400 cycles, nothing more
   a_cancel_length: assert property (obs_cancel |-> frame_cnt_reg inside {[13'h17c:13'h1b8]})
      else $error("cancelled frame length wrong");
endmodule

`default_nettype wire

// >>> dv/serial_bus_frame_control_tb_top.sv
// self-checking bench: initiator and device end joined over sbf_link_if
// assumes the package and interface are compiled first; one 20 mhz clock
`timescale 1ns/1ps
`default_nettype none

module serial_bus_frame_control_tb_top;
   import sbf_pkg::*;
   localparam logic [CODE_W-1:0] SRC_CODE = 10'h0a5;
   localparam logic [CODE_W-1:0] SNK_CODE = 10'h15a;
   localparam logic [CODE_W-1:0] FF_CODE = 10'h033;
   localparam logic [CODE_W-1:0] DUMMY = 10'h3ff;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic [CODE_W-1:0] req_s = 10'h000;
   logic [CODE_W-1:0] req_r = 10'h000;
   logic ld_we = 1'b0;
   logic [4:0] ld_idx = 5'h00;
   logic [7:0] ld_data = 8'h00;
   logic ld_commit = 1'b0;
   logic [2:0] ld_len = 3'h1;
   logic [4:0] rd_idx = 5'h00;
   logic dispose = 1'b0;
   logic req_ready, done, cancelled, retry, src_loaded, src_sent, snk_full;
   logic sem_flag, jam_seen, cancel_report;
   logic [2:0] snk_len;
   logic [7:0] rd_data;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int sent_cnt = 0;
   int cancel_cnt = 0;
   int jam_cnt = 0;
   int retry_cnt = 0;

   sbf_link_if link ();
   sbf_node i_sbf_node (.mclk(mclk), .nrst(nrst), .link(link), .src_code_cfg(SRC_CODE),
      .snk_code_cfg(SNK_CODE), .ff_code_cfg(FF_CODE), .ld_we(ld_we), .ld_idx(ld_idx),
      .ld_data(ld_data), .ld_commit(ld_commit), .ld_len(ld_len), .rd_idx(rd_idx), .dispose(dispose),
      .src_loaded(src_loaded), .src_sent(src_sent), .snk_full(snk_full), .snk_len(snk_len),
      .rd_data(rd_data), .sem_flag(sem_flag), .jam_seen(jam_seen), .cancel_report(cancel_report));
   sbf_initiator i_sbf_initiator (.mclk(mclk), .nrst(nrst), .link(link), .req_valid(req_valid),
      .req_s(req_s), .req_r(req_r), .req_ready(req_ready), .done(done), .cancelled(cancelled),
      .retry(retry));
   sbf_link_asserts i_sbf_link_asserts (.mclk(mclk), .nrst(nrst), .dev_sd_oe(link.dev_sd_oe),
      .ini_sd_oe(link.ini_sd_oe), .obs_busy(link.obs_busy), .obs_free(link.obs_free),
      .obs_cancel(link.obs_cancel), .obs_jam(link.obs_jam), .ini_active(link.ini_active));

   // ---------------------------------------------------------------
   // clock, pulse counters and hang guard
   // ---------------------------------------------------------------
   always #25 mclk = ~mclk;

   // pulses last one cycle, so counting them avoids missing one between polls
   always @(posedge mclk)
   begin
      cycles++;
      if (src_sent === 1'b1) sent_cnt++;
      if (cancel_report === 1'b1) cancel_cnt++;
      if (jam_seen === 1'b1) jam_cnt++;
      if (retry === 1'b1) retry_cnt++;
      if (cycles == 40000)
      begin
         errors++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   function automatic logic [7:0] pat(input int i, input int c);
      pat = 8'(i * 37 + c * 5 + 1);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one frame from request to done; outputs read at edges see settled values
   task automatic send(input logic [CODE_W-1:0] s, input logic [CODE_W-1:0] r, input int exp_cancel,
      input int exp_sent);
      int n;
      logic got_cancel;
      n = 0;
      sent_cnt = 0;
      cancel_cnt = 0;
      @(posedge mclk);
      while (!(req_ready === 1'b1 && link.obs_busy === 1'b0) && n < 200)
      begin
         @(posedge mclk);
         n++;
      end
      req_s <= s;
      req_r <= r;
      req_valid <= 1'b1;
      @(posedge mclk);
      req_valid <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 6000)
      begin
         @(posedge mclk);
         n++;
      end
      check(done, 1);
      got_cancel = cancelled;
      repeat (2) @(posedge mclk);
      check(32'(got_cancel), 32'(exp_cancel));
      check(cancel_cnt, exp_cancel);
      check(sent_cnt, exp_sent);
   endtask

   task automatic load(input int c);
      int i;
      for (i = 0; i < (1 << (c - 1)); i++)
      begin
         @(posedge mclk);
         ld_we <= 1'b1;
         ld_idx <= 5'(i);
         ld_data <= pat(i, c);
      end
      @(posedge mclk);
      ld_we <= 1'b0;
      ld_commit <= 1'b1;
      ld_len <= 3'(c);
      @(posedge mclk);
      ld_commit <= 1'b0;
      @(posedge mclk);
      @(posedge mclk);
      check(src_loaded, 1);
   endtask

   // read back the sink buffer, then free it
   task automatic drain(input int c);
      int i;
      check(snk_full, 1);
      check(snk_len, c);
      for (i = 0; i < (1 << (c - 1)); i++)
      begin
         rd_idx <= 5'(i);
         @(posedge mclk);
         @(posedge mclk);
         check(rd_data, pat(i, c));
      end
      dispose <= 1'b1;
      @(posedge mclk);
      dispose <= 1'b0;
      repeat (2) @(posedge mclk);
      check(snk_full, 0);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_unloaded();
      send(SRC_CODE, SNK_CODE, 1, 0);
      check(snk_full, 0);
      $display("unloaded source test done");
   endtask

   task automatic test_sizes();
      int c;
      for (c = 1; c <= 6; c++)
      begin
         load(c);
         send(SRC_CODE, SNK_CODE, 0, 1);
         check(src_loaded, 0);
         drain(c);
      end
      $display("size code test done");
   endtask

   // sink still full: the second frame is cancelled and the source keeps its data
   task automatic test_full_sink();
      load(2);
      send(SRC_CODE, SNK_CODE, 0, 1);
      load(3);
      send(SRC_CODE, SNK_CODE, 1, 0);
      check(src_loaded, 1);
      check(snk_len, 2);
      drain(2);
      send(SRC_CODE, SNK_CODE, 0, 1);
      drain(3);
      $display("full sink test done");
   endtask

   task automatic test_semaphore();
      send(FF_CODE, DUMMY, 0, 0);
      check(sem_flag, 1);
      send(FF_CODE, DUMMY, 1, 0);
      check(sem_flag, 1);
      send(DUMMY, FF_CODE, 0, 0);
      check(sem_flag, 0);
      send(DUMMY, FF_CODE, 1, 0);
      check(sem_flag, 0);
      check(jam_cnt, 0);
      $display("semaphore test done");
   endtask

   // a glitch in a zero header bit breaks the bit grid: the device jams,
   // the initiator resends after resync and the data then goes through
   task automatic test_jam();
      load(1);
      jam_cnt = 0;
      retry_cnt = 0;
      fork
         send(SRC_CODE, SNK_CODE, 0, 1);
         begin
            @(posedge mclk);
            while (link.ini_sd_oe !== 1'b1)
               @(posedge mclk);
            // covers the device's sample point of the second bit, not its check point
            repeat (23) @(posedge mclk);
            link.noise <= 1'b1;
            repeat (3) @(posedge mclk);
            link.noise <= 1'b0;
         end
      join
      check(jam_cnt, 1);
      check(retry_cnt, 1);
      drain(1);
      $display("jam and resend test done");
   endtask

   initial
   begin
      link.noise <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
      test_unloaded();
      test_sizes();
      test_full_sink();
      test_semaphore();
      test_jam();
      wrap_up();
   end
endmodule

`default_nettype wire
